// [shared/rate_conv_pkg.sv]
// shared constants and types for the rate converter lock and mute block
package rate_conv_pkg;
  localparam int CONV_COUNT      = 8;
  localparam int GROUP_SIZE      = 4;
  localparam int RATE_WIDTH      = 6;
  localparam int SAMPLE_WIDTH    = 24;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [15:0] IDX_LOW_LOCK_MUTE   = 16'hE101;
  localparam logic [15:0] IDX_LOW_RAMP_DIS    = 16'hE103;
  localparam logic [15:0] IDX_HIGH_LOCK_MUTE  = 16'hE141;
  localparam logic [15:0] IDX_HIGH_RAMP_DIS   = 16'hE143;
  localparam logic [15:0] IDX_IRQ_STATUS      = 16'hE150;
  localparam logic [15:0] IDX_IRQ_MASK        = 16'hE151;
  localparam int ADDR_WIDTH      = 18;
  localparam int MUTE_LSB        = 0;
  localparam int LOCK_LSB        = 8;
  localparam int RAMP_DIS_BIT    = 0;
  localparam logic [3:0] MUTE_RESET     = 4'h0;
  localparam logic [3:0] LOCK_RESET     = 4'h0;
  localparam logic       RAMP_DIS_RESET = 1'h0;
  localparam logic [5:0] RATE_NONE      = 6'h3F;
  localparam int RAMP_TIME_US    = 10;
  localparam int CLOCK_MHZ       = 40;
  localparam int RAMP_CYCLES     = RAMP_TIME_US * CLOCK_MHZ;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [SAMPLE_WIDTH-1:0] left;
    logic [SAMPLE_WIDTH-1:0] right;
  } stereo_sample_type;

  typedef enum logic [2:0] {
    GAIN_MUTED  = 3'h1,
    GAIN_RISING = 3'h2,
    GAIN_OPEN   = 3'h4
  } gain_state_type;
endpackage

// [rtl/rate_converter_lock_mute.sv]
// lock tracking, mute control and register slave for eight stereo rate converters
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rate_converter_lock_mute
  import rate_conv_pkg::*;
#(
  parameter int RAMP_LEN      = RAMP_CYCLES,
  parameter bit HAS_CONVERTER = 1'b1
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset,
  // axi4-lite write address, data and response
  input  wire logic [ADDR_WIDTH-1:0]      s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_WIDTH-1:0]      s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // converter status from the same clock domain
  input  wire logic [CONV_COUNT-1:0]      master_clock_enable,
  input  wire logic [CONV_COUNT-1:0]      converter_locked,
  input  wire logic [CONV_COUNT*RATE_WIDTH-1:0] output_rate_select,
  // audio from and to the routing matrix
  input  wire stereo_sample_type [CONV_COUNT-1:0] audio_in,
  input  wire logic                       sample_strobe,
  output stereo_sample_type [CONV_COUNT-1:0] audio_out,
  output logic [CONV_COUNT-1:0]           mute_active,
  // interrupt
  output logic                            irq
);

  localparam int GW = $clog2(RAMP_LEN + 1);
  // worst case from full gain: enter ramp, RAMP_LEN steps, flag register, margin
  localparam int MUTE_BOUND = RAMP_LEN + 4;

  logic [CONV_COUNT-1:0] mute_request;
  logic [1:0]            ramp_disable;
  logic [CONV_COUNT-1:0] lock_flag;
  logic [CONV_COUNT-1:0] irq_status;
  logic [CONV_COUNT-1:0] irq_mask;
  logic [CONV_COUNT-1:0] enable_seen;
  logic                  aw_held;
  logic                  w_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;

  // write path: address and data are taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held || aw_take;
  wire w_have  = w_held || w_take;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire [ADDR_WIDTH-1:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
  wire [15:0] widx = wa[17:2];
  wire wr_aligned  = wa[1:0] == 2'h0;
  // converter registers accept writes only in the converter variant
  wire wr_conv_ok  = HAS_CONVERTER && wr_aligned;
  wire wr_low_mute  = do_write && wr_conv_ok && widx == IDX_LOW_LOCK_MUTE && ws[0];
  wire wr_high_mute = do_write && wr_conv_ok && widx == IDX_HIGH_LOCK_MUTE && ws[0];
  wire wr_low_ramp  = do_write && wr_conv_ok && widx == IDX_LOW_RAMP_DIS && ws[0];
  wire wr_high_ramp = do_write && wr_conv_ok && widx == IDX_HIGH_RAMP_DIS && ws[0];
  wire wr_status = do_write && wr_aligned && widx == IDX_IRQ_STATUS && ws[0];
  wire wr_mask   = do_write && wr_aligned && widx == IDX_IRQ_MASK && ws[0];
  wire wr_mapped = wr_low_mute || wr_high_mute || wr_low_ramp || wr_high_ramp
                   || (wr_aligned && (widx == IDX_IRQ_STATUS || widx == IDX_IRQ_MASK
                   || ((widx == IDX_LOW_LOCK_MUTE || widx == IDX_HIGH_LOCK_MUTE
                   || widx == IDX_LOW_RAMP_DIS || widx == IDX_HIGH_RAMP_DIS))));

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_take && !do_write) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take && !do_write) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge clock) begin
    if (reset) begin
      mute_request <= {MUTE_RESET, MUTE_RESET};
      ramp_disable <= {RAMP_DIS_RESET, RAMP_DIS_RESET};
      irq_mask <= '0;
    end else begin
      if (wr_low_mute)
        mute_request[GROUP_SIZE-1:0] <= wd[MUTE_LSB +: GROUP_SIZE];
      if (wr_high_mute)
        mute_request[CONV_COUNT-1:GROUP_SIZE] <= wd[MUTE_LSB +: GROUP_SIZE];
      if (wr_low_ramp)
        ramp_disable[0] <= wd[RAMP_DIS_BIT];
      if (wr_high_ramp)
        ramp_disable[1] <= wd[RAMP_DIS_BIT];
      if (wr_mask)
        irq_mask <= wd[CONV_COUNT-1:0];
    end
  end

  // lock flag per converter: set once on clock enable, cleared once on lock with a valid rate
  logic [CONV_COUNT-1:0] lock_clear_event;
  logic [CONV_COUNT-1:0] effective_mute;
  genvar gi;
  generate
    for (gi = 0; gi < CONV_COUNT; gi++) begin : g_conv
      wire [RATE_WIDTH-1:0] rate = output_rate_select[gi*RATE_WIDTH +: RATE_WIDTH];
      wire rate_valid = rate != RATE_NONE;
      wire enable_rise = master_clock_enable[gi] && !enable_seen[gi];
      assign lock_clear_event[gi] = lock_flag[gi] && rate_valid && converter_locked[gi];
      assign effective_mute[gi] = lock_flag[gi]
                                  || (mute_request[gi] && !ramp_disable[gi/GROUP_SIZE]);

      always_ff @(posedge clock) begin
        if (reset) begin
          lock_flag[gi] <= LOCK_RESET[0];
          enable_seen[gi] <= 1'b0;
        end else begin
          if (master_clock_enable[gi])
            enable_seen[gi] <= 1'b1;
          // only the first enable after reset raises the flag
          if (enable_rise && HAS_CONVERTER)
            lock_flag[gi] <= 1'b1;
          else if (lock_clear_event[gi])
            lock_flag[gi] <= 1'b0;
        end
      end

      // gain ramp; abrupt when the group disables the ramp
      gain_state_type gstate;
      logic [GW-1:0]  gain;
      wire abrupt = ramp_disable[gi/GROUP_SIZE];
      always_ff @(posedge clock) begin
        if (reset) begin
          gstate <= GAIN_MUTED;
          gain <= '0;
        end else if (abrupt) begin
          gain <= effective_mute[gi] ? '0 : GW'(RAMP_LEN);
          gstate <= effective_mute[gi] ? GAIN_MUTED : GAIN_OPEN;
        end else begin
          case (gstate)
            GAIN_MUTED:  if (!effective_mute[gi]) gstate <= GAIN_RISING;
            GAIN_OPEN:   if (effective_mute[gi]) gstate <= GAIN_RISING;
            GAIN_RISING: begin
              // one step per cycle toward the target keeps the slope click free
              if (effective_mute[gi] && gain != '0)
                gain <= gain - 1'b1;
              else if (!effective_mute[gi] && gain != GW'(RAMP_LEN))
                gain <= gain + 1'b1;
              else
                gstate <= effective_mute[gi] ? GAIN_MUTED : GAIN_OPEN;
            end
            default: gstate <= GAIN_MUTED;
          endcase
        end
      end

      // scale samples by gain / RAMP_LEN; divide is a constant, synthesis folds it
      wire signed [SAMPLE_WIDTH+GW:0] pl =
        $signed(audio_in[gi].left) * $signed({1'b0, gain});
      wire signed [SAMPLE_WIDTH+GW:0] pr =
        $signed(audio_in[gi].right) * $signed({1'b0, gain});
      wire signed [SAMPLE_WIDTH+GW:0] ql = pl / $signed((SAMPLE_WIDTH+GW+1)'(RAMP_LEN));
      wire signed [SAMPLE_WIDTH+GW:0] qr = pr / $signed((SAMPLE_WIDTH+GW+1)'(RAMP_LEN));
      always_ff @(posedge clock) begin
        if (reset) begin
          audio_out[gi] <= '0;
          mute_active[gi] <= 1'b1;
        end else begin
          if (sample_strobe) begin
            audio_out[gi].left <= ql[SAMPLE_WIDTH-1:0];
            audio_out[gi].right <= qr[SAMPLE_WIDTH-1:0];
          end
          mute_active[gi] <= gain == '0;
        end
      end

      AST_ABRUPT_ZERO: assert property (@(posedge clock) disable iff (reset)
        abrupt && $past(abrupt) && effective_mute[gi] |=> gain == '0)
        else $error("abrupt mute did not zero gain");
      AST_RAMP_STEP: assert property (@(posedge clock) disable iff (reset)
        !abrupt && $past(!abrupt) && gstate == GAIN_RISING && effective_mute[gi]
        && gain != '0 |=> gain == $past(gain) - 1'b1)
        else $error("ramp did not step down by one");
    end
  endgenerate

  // interrupt: a lock event sets status; the set wins over a clear
  always_ff @(posedge clock) begin
    if (reset)
      irq_status <= '0;
    else
      irq_status <= (irq_status & ~(wr_status ? wd[CONV_COUNT-1:0] : '0))
                    | lock_clear_event;
  end
  assign irq = |(irq_status & irq_mask);

  // read path
  wire [15:0] ridx = s_axi_araddr[17:2];
  wire r_aligned = s_axi_araddr[1:0] == 2'h0;
  logic [31:0] rd_value;
  logic        rd_hit;
  always_comb begin
    rd_value = '0;
    rd_hit = r_aligned;
    case (ridx)
      IDX_LOW_LOCK_MUTE:  rd_value[11:0] = {lock_flag[3:0], 4'h0, mute_request[3:0]};
      IDX_HIGH_LOCK_MUTE: rd_value[11:0] = {lock_flag[7:4], 4'h0, mute_request[7:4]};
      IDX_LOW_RAMP_DIS:   rd_value[RAMP_DIS_BIT] = ramp_disable[0];
      IDX_HIGH_RAMP_DIS:  rd_value[RAMP_DIS_BIT] = ramp_disable[1];
      IDX_IRQ_STATUS:     rd_value[CONV_COUNT-1:0] = irq_status;
      IDX_IRQ_MASK:       rd_value[CONV_COUNT-1:0] = irq_mask;
      default:            rd_hit = 1'b0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_value : 32'h0;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  AST_LOCK_RESET: assert property (@(posedge clock)
    $fell(reset) |-> lock_flag == '0)
    else $error("lock flags not zero after reset");
  AST_LOCK_SET: assert property (@(posedge clock) disable iff (reset)
    master_clock_enable[0] && !enable_seen[0] && HAS_CONVERTER |=> lock_flag[0])
    else $error("clock enable did not set lock flag");
  AST_LOCK_STICKY: assert property (@(posedge clock) disable iff (reset)
    enable_seen[0] && !lock_flag[0] |=> !lock_flag[0])
    else $error("cleared lock flag returned to one");
  AST_LOCK_CLEAR: assert property (@(posedge clock) disable iff (reset)
    lock_clear_event[0] && !(master_clock_enable[0] && !enable_seen[0]) |=> !lock_flag[0])
    else $error("lock flag not cleared on lock");
  AST_NO_RATE: assert property (@(posedge clock) disable iff (reset)
    output_rate_select[(CONV_COUNT-1)*RATE_WIDTH +: RATE_WIDTH] == RATE_NONE
    && lock_flag[CONV_COUNT-1] |=> lock_flag[CONV_COUNT-1])
    else $error("lock cleared without a rate");
  AST_AUTO_MUTE: assert property (@(posedge clock) disable iff (reset)
    lock_flag[1] |-> ##[1:MUTE_BOUND] mute_active[1])
    else $error("unlocked converter not muted");
  AST_REQ_IGNORED: assert property (@(posedge clock) disable iff (reset)
    ramp_disable[1] && !lock_flag[5] |-> !effective_mute[5])
    else $error("request obeyed while ramp disabled");
  AST_MUTE_WRITE: assert property (@(posedge clock) disable iff (reset)
    wr_low_mute |=> mute_request[3:0] == $past(wd[3:0]))
    else $error("mute request write lost");
  AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (reset)
    $past(lock_clear_event[0]) && irq_mask[0] |-> irq)
    else $error("interrupt missing after lock event");

endmodule
`default_nettype wire

// [test/routing_matrix_model.sv]
// behavioural routing matrix and converter status source facing the block
`timescale 1ns/1ps
`default_nettype none
module routing_matrix_model
  import rate_conv_pkg::*;
(
  // clock and reset
  input  wire logic                                clock,
  input  wire logic                                reset,
  // commands from the bench
  input  wire logic [CONV_COUNT-1:0]               clk_en_cmd,
  input  wire logic [CONV_COUNT-1:0]               lock_cmd,
  input  wire logic [CONV_COUNT*RATE_WIDTH-1:0]    rate_cmd,
  // status and audio towards the block
  output logic [CONV_COUNT-1:0]                    master_clock_enable = '0,
  output logic [CONV_COUNT-1:0]                    converter_locked = '0,
  output logic [CONV_COUNT*RATE_WIDTH-1:0]         output_rate_select = '1,
  output stereo_sample_type [CONV_COUNT-1:0]       audio_in = '0,
  output logic                                     sample_strobe = 1'b0
);
  logic [1:0] phase = 2'h0;
  // fresh random samples each frame so a stuck gain path cannot pass by luck
  always @(posedge clock) begin
    phase <= reset ? 2'h0 : phase + 2'h1;
    sample_strobe <= (phase == 2'h3);
    master_clock_enable <= clk_en_cmd;
    converter_locked <= lock_cmd;
    output_rate_select <= rate_cmd;
    if (phase == 2'h3) begin
      for (int i = 0; i < CONV_COUNT; i++) audio_in[i] <= 48'({$urandom, $urandom});
    end
  end
endmodule
`default_nettype wire

// [test/rate_converter_lock_mute_tb_top.sv]
// self-checking bench for the rate converter lock and mute block
`timescale 1ns/1ps
`default_nettype none
module rate_converter_lock_mute_tb_top;
  import rate_conv_pkg::*;
  logic clock = 1'b0, reset = 1'b1;
  logic [ADDR_WIDTH-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, d, seed;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, strobe;
  logic [1:0] bresp, rresp, r;
  logic [7:0] en_cmd = '0, lk_cmd = '0, mute_active, mce, lkd;
  logic [47:0] rate_cmd = '1, ors;
  stereo_sample_type [7:0] ain, aout;
  logic [7:0] bare_mute;
  logic bare_irq;
  int n_errors = 0, tests_run = 0;
  // reference model state
  logic [7:0] m_lock = '0, m_req = '0, m_stat = '0, m_mask = '0;
  logic [1:0] m_rd = '0;
  localparam logic [15:0] IDXS [6] = '{IDX_LOW_LOCK_MUTE, IDX_LOW_RAMP_DIS, IDX_HIGH_LOCK_MUTE,
                                       IDX_HIGH_RAMP_DIS, IDX_IRQ_STATUS, IDX_IRQ_MASK};

  initial forever #12.5 clock = ~clock;

  rate_converter_lock_mute #(.RAMP_LEN(8), .HAS_CONVERTER(1'b1)) i_dut (
    .clock(clock), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .master_clock_enable(mce), .converter_locked(lkd), .output_rate_select(ors),
    .audio_in(ain), .sample_strobe(strobe), .audio_out(aout), .mute_active(mute_active),
    .irq(irq));

  routing_matrix_model i_far (
    .clock(clock), .reset(reset), .clk_en_cmd(en_cmd), .lock_cmd(lk_cmd), .rate_cmd(rate_cmd),
    .master_clock_enable(mce), .converter_locked(lkd), .output_rate_select(ors),
    .audio_in(ain), .sample_strobe(strobe));

  // variant without converters on the same bus; its bus answers go unused
  rate_converter_lock_mute #(.RAMP_LEN(8), .HAS_CONVERTER(1'b0)) i_bare (
    .clock(clock), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .master_clock_enable(mce), .converter_locked(lkd), .output_rate_select(ors),
    .audio_in(ain), .sample_strobe(strobe), .audio_out(), .mute_active(bare_mute),
    .irq(bare_irq));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang;
    check("handshake", 32'h1, 32'h0);
    close_out();
  endtask

  function automatic logic [ADDR_WIDTH-1:0] ba(input logic [15:0] i);
    return {i, 2'b00};
  endfunction

  function automatic logic [31:0] exp_reg(input logic [15:0] i);
    case (i)
      IDX_LOW_LOCK_MUTE: return {20'h0, m_lock[3:0], 4'h0, m_req[3:0]};
      IDX_HIGH_LOCK_MUTE: return {20'h0, m_lock[7:4], 4'h0, m_req[7:4]};
      IDX_LOW_RAMP_DIS: return {31'h0, m_rd[0]};
      IDX_HIGH_RAMP_DIS: return {31'h0, m_rd[1]};
      IDX_IRQ_STATUS: return {24'h0, m_stat};
      default: return {24'h0, m_mask};
    endcase
  endfunction

  function automatic logic [7:0] eff;
    for (int i = 0; i < 8; i++) eff[i] = m_lock[i] | (m_req[i] & ~m_rd[i/4]);
  endfunction

  // address and data go out together; each is dropped only once taken
  task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [31:0] dv);
    bit aw_hit, w_hit, b_hit;
    int n;
    #1;
    n = 0;
    b_hit = 0;
    awaddr <= a;
    wdata <= dv;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hit && n < 200) begin
      @(negedge clock);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid;
      r = bresp;
      @(posedge clock);
      n++;
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_hit) hang();
  endtask

  task automatic rd(input logic [ADDR_WIDTH-1:0] a);
    bit ar_hit, r_hit;
    int n;
    #1;
    n = 0;
    r_hit = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hit && n < 200) begin
      @(negedge clock);
      ar_hit = arvalid && arready;
      r_hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      n++;
      if (ar_hit) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!r_hit) hang();
  endtask

  task automatic wr_ok(input logic [15:0] i, input logic [31:0] dv);
    wr(ba(i), dv);
    check("bresp", 32'(RESP_OKAY), 32'(r));
  endtask

  task automatic rd_chk(input logic [15:0] i);
    rd(ba(i));
    check("rresp", 32'(RESP_OKAY), 32'(r));
    check("register", exp_reg(i), d);
  endtask

  task automatic rd_all;
    for (int i = 0; i < 6; i++) rd_chk(IDXS[i]);
  endtask

  // waits for the mute vector, bounds how long it took, then checks silenced audio
  task automatic settle(input int lo, input int hi);
    int n;
    logic [7:0] e;
    e = eff();
    n = 0;
    #1;
    while (mute_active !== e && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("mute_active", 32'(e), 32'(mute_active));
    check("settle window", 32'h1, 32'(n >= lo && n <= hi));
    repeat (8) @(posedge clock);
    #1;
    for (int i = 0; i < 8; i++) if (e[i]) check("muted audio", 32'h0, 32'(aout[i] != '0));
  endtask

  task automatic chk_irq;
    #1;
    check("irq", 32'(|(m_stat & m_mask)), 32'(irq));
  endtask

  initial begin
    seed = $urandom(32'h70DD);
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd_all();
    rd(ba(16'hE102));
    check("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    wr(ba(16'hE102), 32'hFFFFFFFF);
    check("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
    settle(0, 40);
    en_cmd <= 8'hFF;
    m_lock = 8'hFF;
    repeat (3) @(posedge clock);
    rd_all();
    settle(0, 40);
    repeat (4) begin
      d = $urandom;
      wr_ok(IDX_LOW_LOCK_MUTE, d);
      m_req[3:0] = d[3:0];
      d = $urandom;
      wr_ok(IDX_HIGH_LOCK_MUTE, d);
      m_req[7:4] = d[3:0];
      rd_all();
    end
    // unmask converter 0 so its lock event raises the interrupt line
    m_mask = 8'h01;
    wr_ok(IDX_IRQ_MASK, 32'h01);
    rate_cmd <= {RATE_NONE, 42'h0};
    lk_cmd <= 8'hFF;
    m_lock = 8'h80;
    m_stat = 8'h7F;
    repeat (3) @(posedge clock);
    rd_all();
    chk_irq();
    m_mask = 8'h00;
    wr_ok(IDX_IRQ_MASK, 32'h0);
    // dropping clocks and rates afterwards must not bring any flag back
    en_cmd <= 8'h00;
    lk_cmd <= 8'h00;
    rate_cmd <= '1;
    repeat (3) @(posedge clock);
    en_cmd <= 8'hFF;
    repeat (3) @(posedge clock);
    rd_all();
    m_req = 8'h00;
    wr_ok(IDX_LOW_LOCK_MUTE, 32'h0);
    wr_ok(IDX_HIGH_LOCK_MUTE, 32'h0);
    settle(0, 40);
    m_req[3:0] = 4'h5;
    wr_ok(IDX_LOW_LOCK_MUTE, 32'h5);
    settle(4, 40);
    m_rd[0] = 1'b1;
    wr_ok(IDX_LOW_RAMP_DIS, 32'hFFFFFFFF);
    settle(0, 3);
    m_req[7:4] = 4'hF;
    wr_ok(IDX_HIGH_LOCK_MUTE, 32'hF);
    settle(4, 40);
    m_rd[1] = 1'b1;
    wr_ok(IDX_HIGH_RAMP_DIS, 32'h1);
    settle(0, 3);
    m_rd[0] = 1'b0;
    wr_ok(IDX_LOW_RAMP_DIS, 32'h0);
    settle(4, 40);
    rd_all();
    chk_irq();
    m_mask = 8'h01;
    wr_ok(IDX_IRQ_MASK, 32'h01);
    chk_irq();
    m_stat = 8'h7E;
    wr_ok(IDX_IRQ_STATUS, 32'h01);
    chk_irq();
    m_mask = 8'h80;
    wr_ok(IDX_IRQ_MASK, 32'h80);
    chk_irq();
    m_mask = 8'h02;
    wr_ok(IDX_IRQ_MASK, 32'h02);
    chk_irq();
    rd_all();
    check("bare mute_active", 32'h0, 32'(bare_mute));
    check("bare irq", 32'h0, 32'(bare_irq));
    close_out();
  end
endmodule
`default_nettype wire
